// File: design/program_memory_table_read.sv
// module: table pointer, table latch and table read sequencing
`timescale 1ns/100ps
// Function
// RQ1: program memory is only read, one byte per table read.
// RQ2: every byte moves from program memory to data RAM through one 8-bit latch.
// RQ3: the 8-bit latch is a register in the special function register space.
// RQ4: the 22-bit pointer is upper bits 5:0, then the high byte, then the low byte.
// RQ5: pointer bits 20:0 address program space and bit 21 selects configuration space.
// RQ6: automatic pointer steps change only bits 20:0 and leave bit 21 alone.
// RQ7: all 22 pointer bits choose the byte loaded into the latch.
// RQ8: reads keep, post-increment, post-decrement or pre-increment the pointer.
// RQ9: pointer bit 0 chooses the high or low byte of a memory word.
// RQ10: reads work at any byte address with no word alignment.
// RQ11: a table write in normal operation is a two-cycle no-operation.
// RQ12: a table write takes effect only in programming mode.
// RQ13: unused upper pointer bits read as zero.
// RQ14: a pointer write is used by the next table read after that write; a pointer write in the same cycle as a stepping read is lost instead.
module program_memory_table_read
	import table_read_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// special function register port
	input wire sfr_req_t sfr_req_i,
	output logic [BYTE_W-1:0] sfr_rdata_o,
	// table operations from the core
	input wire op_req_t op_req_i,
	input wire logic prog_mode_i,
	output logic busy_o,
	output logic done_o,
	// program memory array
	output logic mem_rd_o,
	output logic mem_cfg_o,
	output logic [MEM_ADDR_W-1:0] mem_addr_o,
	input wire logic [WORD_W-1:0] mem_rdata_i,
	// programming path for table writes
	output logic prog_wr_o,
	output logic [PTR_W-1:0] prog_addr_o,
	output logic [BYTE_W-1:0] prog_data_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	state_t state, next_state;
	logic [PTR_W-1:0] ptr, next_ptr;
	logic [BYTE_W-1:0] latch, next_latch;
	logic [BYTE_W-1:0] rdata, next_rdata;
	logic busy, next_busy;
	logic done, next_done;
	logic mem_rd, next_mem_rd;
	logic mem_cfg, next_mem_cfg;
	logic [MEM_ADDR_W-1:0] mem_addr, next_mem_addr;
	logic prog_wr, next_prog_wr;
	logic [PTR_W-1:0] prog_addr, next_prog_addr;
	logic [BYTE_W-1:0] prog_data, next_prog_data;
	logic byte_high, next_byte_high;
	logic [BYTE_W-1:0] mem_byte;

	// ---------------------------------------------------------------
	// byte select
	// ---------------------------------------------------------------
	// the select bit is registered with the word address, so it still
	// matches the word that the array returns in the strobe cycle
	table_byte_select u_byte_select (
		.word_i(mem_rdata_i),
		.high_i(byte_high),
		.byte_o(mem_byte)
	);

	// ---------------------------------------------------------------
	// pointer step helpers
	// ---------------------------------------------------------------
	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic up);
		logic [CNT_W-1:0] low;
		low = up ? (p[CNT_W-1:0] + PTR_STEP) : (p[CNT_W-1:0] - PTR_STEP);
		// the carry out of bit 20 drops here, so a step never flips the space select
		return {p[PTR_W-1], low}; // [RQ6]
	endfunction : ptr_step

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [PTR_W-1:0] rd_ptr;
		rd_ptr = ptr;
		next_state = state;
		next_ptr = ptr;
		next_latch = latch;
		next_busy = busy;
		next_done = 1'b0;
		next_mem_rd = 1'b0;
		next_mem_cfg = mem_cfg;
		next_mem_addr = mem_addr;
		next_prog_wr = 1'b0;
		next_prog_addr = prog_addr;
		next_prog_data = prog_data;
		next_byte_high = byte_high;
		// register writes land at the clock edge; a read taken in the same cycle still uses the old pointer
		if (sfr_req_i.valid && sfr_req_i.write) begin
			case (sfr_req_i.sel)
				SEL_LATCH: next_latch = sfr_req_i.data;
				SEL_LOW: next_ptr[BYTE_W-1:0] = sfr_req_i.data; // [RQ14]
				SEL_HIGH: next_ptr[2*BYTE_W-1:BYTE_W] = sfr_req_i.data; // [RQ14]
				SEL_UPPER: next_ptr[PTR_W-1:2*BYTE_W] = sfr_req_i.data[UPPER_USED_W-1:0]; // [RQ4]
				default: next_latch = latch;
			endcase
		end
		// one operation at a time: requests outside the idle state are dropped
		case (state)
			ST_IDLE: begin
				if (op_req_i.valid) begin
					next_busy = 1'b1;
					if (op_req_i.op == OP_TABLE_WRITE) begin
						// pointer and latch stay as they are; outside programming mode only the timing shows
						next_state = ST_WRITE_NOP; // [RQ11]
						// the programming path gets pointer and latch as they stand
						if (prog_mode_i) begin
							next_prog_wr = 1'b1; // [RQ12]
							next_prog_addr = ptr;
							next_prog_data = latch;
						end
					end else begin
						if (op_req_i.op == OP_READ_PRE_INCREMENT) begin
							rd_ptr = ptr_step(ptr, 1'b1); // [RQ8]
						end
						// the array answers combinationally in the strobe cycle
						// read-only array: only a read strobe exists [RQ1]
						next_mem_rd = 1'b1;
						next_mem_cfg = rd_ptr[PTR_W-1]; // [RQ5] [RQ7]
						next_mem_addr = {1'b0, rd_ptr[CNT_W-1:1]}; // [RQ10]
						next_byte_high = rd_ptr[0]; // [RQ9]
						// a pointer write on the same edge as a stepping read is lost, as the
						// step starts from the old pointer; software leaves a cycle between
						case (op_req_i.op)
							OP_READ_POST_INCREMENT: next_ptr = ptr_step(ptr, 1'b1); // [RQ8]
							OP_READ_POST_DECREMENT: next_ptr = ptr_step(ptr, 1'b0); // [RQ8]
							OP_READ_PRE_INCREMENT: next_ptr = rd_ptr; // [RQ8]
							default: next_ptr = next_ptr;
						endcase
						next_state = ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				// a latch write in this cycle loses to the fetched byte
				next_latch = mem_byte; // [RQ2] [RQ3]
				next_busy = 1'b0;
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			ST_WRITE_NOP: begin
				next_busy = 1'b0;
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
		// read data is registered and then held until the next read
		case (sfr_req_i.sel)
			SEL_LATCH: next_rdata = latch;
			SEL_LOW: next_rdata = ptr[BYTE_W-1:0];
			SEL_HIGH: next_rdata = ptr[2*BYTE_W-1:BYTE_W];
			SEL_UPPER: next_rdata = {2'b00, ptr[PTR_W-1:2*BYTE_W]} & UPPER_MASK; // [RQ13]
			default: next_rdata = LATCH_RESET;
		endcase
		if (!(sfr_req_i.valid && !sfr_req_i.write)) begin
			next_rdata = rdata;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// synchronous reset only; the core clock keeps running while it is held
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			ptr <= PTR_RESET;
			latch <= LATCH_RESET;
			rdata <= LATCH_RESET;
			busy <= 1'b0;
			done <= 1'b0;
			mem_rd <= 1'b0;
			mem_cfg <= 1'b0;
			mem_addr <= '0;
			prog_wr <= 1'b0;
			prog_addr <= PTR_RESET;
			prog_data <= LATCH_RESET;
			byte_high <= 1'b0;
		end else begin
			state <= next_state;
			ptr <= next_ptr;
			latch <= next_latch;
			rdata <= next_rdata;
			busy <= next_busy;
			done <= next_done;
			mem_rd <= next_mem_rd;
			mem_cfg <= next_mem_cfg;
			mem_addr <= next_mem_addr;
			prog_wr <= next_prog_wr;
			prog_addr <= next_prog_addr;
			prog_data <= next_prog_data;
			byte_high <= next_byte_high;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// every output is a register copied straight out, nothing decoded after it
	assign sfr_rdata_o = rdata;
	assign busy_o = busy;
	assign done_o = done;
	assign mem_rd_o = mem_rd;
	assign mem_cfg_o = mem_cfg;
	assign mem_addr_o = mem_addr;
	assign prog_wr_o = prog_wr;
	assign prog_addr_o = prog_addr;
	assign prog_data_o = prog_data;
endmodule : program_memory_table_read

// File: design/table_byte_select.sv
// module: picks one byte of a program memory word by the pointer lsb
`timescale 1ns/100ps
module table_byte_select
	import table_read_pkg::*;
(
	// word and select
	input wire logic [WORD_W-1:0] word_i,
	input wire logic high_i,
	// byte out
	output logic [BYTE_W-1:0] byte_o
);
	always_comb begin
		byte_o = high_i ? word_i[WORD_W-1:BYTE_W] : word_i[BYTE_W-1:0]; // [RQ9]
	end
endmodule : table_byte_select

// File: design/table_read_pkg.sv
// package: table read block constants, types and register selects
package table_read_pkg;
	localparam int PTR_W = 22;
	localparam int CNT_W = 21;
	localparam int UPPER_USED_W = 6;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int MEM_ADDR_W = 21;
	localparam logic [7:0] UPPER_MASK = 8'h3F;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
	localparam logic [CNT_W-1:0] PTR_STEP = 21'h000001;
	localparam int WRITE_NOP_CYCLES = 2;

	// register selects on the special function register port
	typedef enum logic [1:0] {
		SEL_LATCH = 2'h0,
		SEL_LOW = 2'h1,
		SEL_HIGH = 2'h2,
		SEL_UPPER = 2'h3
	} reg_sel_t;

	// table operation codes from the core
	typedef enum logic [2:0] {
		OP_READ_NO_CHANGE = 3'h0,
		OP_READ_POST_INCREMENT = 3'h1,
		OP_READ_POST_DECREMENT = 3'h2,
		OP_READ_PRE_INCREMENT = 3'h3,
		OP_TABLE_WRITE = 3'h4
	} table_op_t;

	typedef struct packed {
		logic valid;
		logic write;
		reg_sel_t sel;
		logic [BYTE_W-1:0] data;
	} sfr_req_t;

	typedef struct packed {
		logic valid;
		table_op_t op;
	} op_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_WRITE_NOP = 2'b11
	} state_t;
endpackage : table_read_pkg

// File: tb/mem_model.sv
// partner: program memory word array
`timescale 1ns/100ps
module mem_model (
	// fetch
	input wire logic rd_i,
	input wire logic cfg_i,
	input wire logic [20:0] addr_i,
	// word
	output logic [15:0] rdata_o
);
	function automatic logic [15:0] word_at(input logic c, input logic [20:0] a);
		return {a[7:0] ^ {3'h0, a[20:16]}, a[15:8] ^ {7'h00, c}};
	endfunction : word_at
	// off the strobe the word is inverted so a late sample shows
	assign rdata_o = rd_i ? word_at(cfg_i, addr_i) : ~word_at(cfg_i, addr_i);
endmodule : mem_model

// File: tb/program_memory_table_read_tb_top.sv
// bench: table read block scenarios
`timescale 1ns/100ps
module program_memory_table_read_tb_top;
	import table_read_pkg::*;
	logic core_clk_i = 1'h0, srst_i = 1'h1, prog_mode_i = 1'h0;
	logic busy_o, done_o, mem_rd_o, mem_cfg_o, prog_wr_o;
	logic [7:0] sfr_rdata_o, prog_data_o, got;
	logic [20:0] mem_addr_o;
	logic [21:0] prog_addr_o, ptr;
	logic [15:0] mem_rdata_i, w;
	logic [29:0] pw;
	sfr_req_t sfr_req_i = '0;
	op_req_t op_req_i = '0;
	int miscompares = 0, comparisons = 0;
	always #4 core_clk_i = ~core_clk_i;
	program_memory_table_read i_dut (.core_clk_i, .srst_i, .sfr_req_i, .sfr_rdata_o,
		.op_req_i, .prog_mode_i, .busy_o, .done_o, .mem_rd_o, .mem_cfg_o, .mem_addr_o,
		.mem_rdata_i, .prog_wr_o, .prog_addr_o, .prog_data_o);
	mem_model i_mem (.rd_i(mem_rd_o), .cfg_i(mem_cfg_o), .addr_i(mem_addr_o),
		.rdata_o(mem_rdata_i));
	task automatic check(input logic [29:0] seen, input logic [29:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t %h %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task automatic sfr(input logic wr, input reg_sel_t sel, input logic [7:0] d);
		sfr_req_i <= '{1'h1, wr, sel, d};
		@(posedge core_clk_i);
		sfr_req_i <= '0;
		@(posedge core_clk_i);
		got = sfr_rdata_o;
	endtask : sfr
	// unused upper bits are always written as ones so every readback tests them
	task automatic set_ptr(input logic [21:0] p);
		sfr(1'h1, SEL_UPPER, {2'h3, p[21:16]});
		sfr(1'h1, SEL_HIGH, p[15:8]);
		sfr(1'h1, SEL_LOW, p[7:0]);
	endtask : set_ptr
	task automatic check_ptr(input logic [21:0] p);
		logic [15:0] v;
		sfr(1'h0, SEL_UPPER, 8'h00);
		v[15:8] = got;
		sfr(1'h0, SEL_HIGH, 8'h00);
		v[7:0] = got;
		sfr(1'h0, SEL_LOW, 8'h00);
		check({v, got}, {2'h0, p});
	endtask : check_ptr
	task automatic op(input table_op_t code);
		int n = 0;
		pw = '0;
		op_req_i <= '{1'h1, code};
		@(posedge core_clk_i);
		// request is dropped once, here, so a following call may raise it again
		op_req_i <= '0;
		while (done_o !== 1'h1 && n < 8) begin
			@(posedge core_clk_i);
			n++;
			if (prog_wr_o === 1'h1)
				pw = {prog_data_o, prog_addr_o};
		end
		if (done_o !== 1'h1) begin
			miscompares++;
			results();
		end
	endtask : op
	task automatic read_ops();
		logic [21:0] start [4] = '{22'h1FFFFF, 22'h3FFFFF, 22'h200000, 22'h012345};
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 4; k++) begin
				ptr = start[s];
				set_ptr(ptr);
				if (k == 3)
					ptr[20:0] += 21'h1;
				w = i_mem.word_at(ptr[21], {1'h0, ptr[20:1]});
				op(table_op_t'(k));
				sfr(1'h0, SEL_LATCH, 8'h00);
				check(got, ptr[0] ? w[15:8] : w[7:0]);
				if (k == 1)
					ptr[20:0] += 21'h1;
				if (k == 2)
					ptr[20:0] -= 21'h1;
				check_ptr(ptr);
			end
		end
	endtask : read_ops
	task automatic write_ops();
		set_ptr(22'h2ABCDE);
		sfr(1'h1, SEL_LATCH, 8'hA5);
		op(OP_TABLE_WRITE);
		check(pw, 30'h0);
		prog_mode_i <= 1'h1;
		op(OP_TABLE_WRITE);
		check(pw, {8'hA5, 22'h2ABCDE});
		sfr(1'h0, SEL_LATCH, 8'h00);
		check(got, 8'hA5);
		check_ptr(22'h2ABCDE);
	endtask : write_ops
	initial begin
		repeat (6) @(posedge core_clk_i);
		srst_i <= 1'h0;
		@(posedge core_clk_i);
		check_ptr(22'h000000);
		sfr(1'h0, SEL_LATCH, 8'h00);
		check(got, LATCH_RESET);
		read_ops();
		write_ops();
		results();
	end
endmodule : program_memory_table_read_tb_top

// File: tb/tr_assertions.sv
// checker: table read block port relations
`timescale 1ns/100ps
module tr_checker
	import table_read_pkg::*;
(
	// watched ports
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire sfr_req_t sfr_req_i,
	input wire logic [BYTE_W-1:0] sfr_rdata_o,
	input wire op_req_t op_req_i,
	input wire logic prog_mode_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic mem_rd_o,
	input wire logic prog_wr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	logic go, wr, pw, rd;
	assign go = op_req_i.valid && !busy_o;
	assign wr = go && op_req_i.op == OP_TABLE_WRITE;
	assign pw = wr && prog_mode_i;
	assign rd = sfr_req_i.valid && !sfr_req_i.write;
	sequence s_nop;
		busy_o && !mem_rd_o ##1 done_o && !busy_o;
	endsequence
	AST_FETCH: assert property (go && !op_req_i.op[2] |=> mem_rd_o && busy_o)
		else $error("no fetch");
	AST_LOAD: assert property (mem_rd_o |=> done_o && !busy_o && !mem_rd_o)
		else $error("fetch open");
	AST_NOP: assert property (wr |=> s_nop)
		else $error("bad write timing");
	AST_QUIET: assert property (wr && !prog_mode_i |=> !prog_wr_o)
		else $error("write acted");
	AST_PROG: assert property (pw |=> prog_wr_o ##1 !prog_wr_o)
		else $error("no pulse");
	AST_CAUSE: assert property (prog_wr_o |-> $past(pw))
		else $error("stray pulse");
	AST_UPPER: assert property (rd && sfr_req_i.sel == SEL_UPPER |=> !sfr_rdata_o[7:6])
		else $error("upper bits set");
	AST_HOLD: assert property (!rd |=> $stable(sfr_rdata_o))
		else $error("read data moved");
endmodule : tr_checker
bind program_memory_table_read tr_checker i_checker (.core_clk_i, .srst_i, .sfr_req_i,
	.sfr_rdata_o, .op_req_i, .prog_mode_i, .busy_o, .done_o, .mem_rd_o, .prog_wr_o);
